/* File: design/spm_top.sv */
// Serial port pin, select mode and byte shifter logic with register slave
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
module spm_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [spm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [spm_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [spm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [spm_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic sel_in_n,
  output logic sel_out_n,
  output logic sel_oe,
  output logic sel_routed,
  output logic irq
);
  // Control and configuration
  logic port_enable_flag;
  logic master_enable_flag;
  logic [1:0] select_mode_field;
  logic select_mode_upper_bit;
  logic select_mode_lower_bit;
  logic [spm_pkg::EVT_W-1:0] status_reg;
  logic [spm_pkg::EVT_W-1:0] status_next;
  logic [spm_pkg::EVT_W-1:0] mask_reg;
  logic [spm_pkg::DIV_W-1:0] div_reg;
  // Bus slave state
  logic aw_have_reg;
  logic w_have_reg;
  logic [spm_pkg::ADDR_W-1:0] awaddr_reg;
  logic [spm_pkg::DATA_W-1:0] wdata_reg;
  logic wstrb0_reg;
  logic do_write;
  logic wr_hit;
  logic rd_data_hit;
  // Synchronised pins and edges
  logic [3:0] pins_s;
  logic sck_s;
  logic sel_s;
  logic mosi_s;
  logic miso_s;
  logic sck_d_reg;
  logic sel_d_reg;
  logic sck_rise;
  logic sck_fall;
  logic sel_fall;
  // Datapath
  logic [spm_pkg::BYTE_W-1:0] shift_reg;
  logic [spm_pkg::BYTE_W-1:0] tx_buf_reg;
  logic [spm_pkg::BYTE_W-1:0] rx_buf_reg;
  logic tx_full_reg;
  logic rx_full_reg;
  logic loaded_reg;
  logic bit_reg;
  logic s_mid_reg;
  logic [spm_pkg::CNT_W-1:0] cnt_reg;
  logic sck_reg;
  spm_pkg::spm_mstate_t mstate_reg;
  logic as_master;
  logic as_slave;
  logic selected;
  logic slave_active;
  logic div_tick;
  logic m_start;
  logic m_rise;
  logic m_fall;
  logic s_rise;
  logic s_fall;
  logic byte_done;
  logic mode_fault;
  logic tx_load;
  logic wcol;

  // Register address match helper
  function automatic logic is_addr(input logic [spm_pkg::ADDR_W-1:0] a,
                                   input logic [spm_pkg::ADDR_W-1:0] ofs);
    is_addr = (a == ofs);
  endfunction

  function automatic logic mapped(input logic [spm_pkg::ADDR_W-1:0] a);
    mapped = is_addr(a, spm_pkg::OFS_CTRL) || is_addr(a, spm_pkg::OFS_STATUS) ||
             is_addr(a, spm_pkg::OFS_MASK) || is_addr(a, spm_pkg::OFS_DATA) ||
             is_addr(a, spm_pkg::OFS_DIV) || is_addr(a, spm_pkg::OFS_PINS);
  endfunction

  assign select_mode_field = {select_mode_upper_bit, select_mode_lower_bit};

  // Pins pass two flip-flops before use
  spm_sync #(
    .WIDTH(4)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({miso_in, mosi_in, !sel_in_n, sck_in}),
    .sync_out(pins_s)
  );

  assign sck_s = pins_s[0];
  // Select enters inverted so a cleared synchroniser reads idle
  assign sel_s = !pins_s[1];
  assign mosi_s = pins_s[2];
  assign miso_s = pins_s[3];

  // Edge detection on synchronised lines
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_d_reg <= 1'b0;
      sel_d_reg <= 1'b1;
    end else begin
      sck_d_reg <= sck_s;
      sel_d_reg <= sel_s;
    end
  end

  assign sck_rise = sck_s && !sck_d_reg;
  assign sck_fall = !sck_s && sck_d_reg;
  assign sel_fall = sel_d_reg && !sel_s;

  // Role and selection
  assign as_master = port_enable_flag && master_enable_flag;
  assign as_slave = port_enable_flag && !master_enable_flag;
  assign selected = (select_mode_field == spm_pkg::SEL_3WIRE) ||
                    ((select_mode_field == spm_pkg::SEL_4W_IN) && !sel_s);
  assign slave_active = as_slave && selected;

  // Pin drive and direction
  assign mosi_oe = as_master;
  assign mosi_out = shift_reg[spm_pkg::BYTE_W-1];
  assign miso_oe = slave_active;
  assign miso_out = shift_reg[spm_pkg::BYTE_W-1];
  assign sck_oe = as_master;
  assign sck_out = sck_reg;
  assign sel_routed = (select_mode_field != spm_pkg::SEL_3WIRE);
  assign sel_oe = select_mode_upper_bit;
  assign sel_out_n = select_mode_lower_bit;

  // Master serial clock timing
  spm_clk_div #(
    .DIV_W(spm_pkg::DIV_W)
  ) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(mstate_reg != spm_pkg::SPM_M_IDLE),
    .half_div(div_reg),
    .tick(div_tick)
  );

  // Multi-master fault: select falls while master in mode 01
  assign mode_fault = as_master && (select_mode_field == spm_pkg::SEL_4W_IN) &&
                      sel_fall;

  assign m_start = as_master && !mode_fault && tx_full_reg &&
                   (mstate_reg == spm_pkg::SPM_M_IDLE);
  assign m_rise = div_tick && (mstate_reg == spm_pkg::SPM_M_LOW);
  assign m_fall = div_tick && (mstate_reg == spm_pkg::SPM_M_HIGH);
  assign s_rise = slave_active && sck_rise;
  assign s_fall = slave_active && sck_fall;
  assign byte_done = (m_fall || s_fall) && (cnt_reg == spm_pkg::CNT_W'(7));

  // Slave loads waiting byte only between bytes
  assign tx_load = m_start || (as_slave && tx_full_reg && !loaded_reg &&
                   cnt_reg == '0 && !s_mid_reg && !s_rise);

  // Master sequencer and serial clock level
  always_ff @(posedge aclk) begin
    if (!aresetn || !as_master || mode_fault) begin
      mstate_reg <= spm_pkg::SPM_M_IDLE;
      sck_reg <= 1'b0;
    end else begin
      unique case (mstate_reg)
        spm_pkg::SPM_M_IDLE: begin
          if (m_start) mstate_reg <= spm_pkg::SPM_M_LOW;
        end
        spm_pkg::SPM_M_LOW: begin
          if (m_rise) begin
            mstate_reg <= spm_pkg::SPM_M_HIGH;
            sck_reg <= 1'b1;
          end
        end
        spm_pkg::SPM_M_HIGH: begin
          if (m_fall) begin
            sck_reg <= 1'b0;
            mstate_reg <= byte_done ? spm_pkg::SPM_M_IDLE : spm_pkg::SPM_M_LOW;
          end
        end
        default: begin
          mstate_reg <= spm_pkg::SPM_M_IDLE;
        end
      endcase
    end
  end

  // Capture on rising edge, shift on falling edge, MSB first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_reg <= '0;
      bit_reg <= 1'b0;
    end else begin
      if (tx_load) begin
        shift_reg <= tx_buf_reg;
      end else if (m_fall || s_fall) begin
        shift_reg <= {shift_reg[spm_pkg::BYTE_W-2:0], bit_reg};
      end
      if (m_rise) begin
        bit_reg <= miso_s;
      end else if (s_rise) begin
        bit_reg <= mosi_s;
      end
    end
  end

  // Bit counter; disable or select falling edge restarts it
  always_ff @(posedge aclk) begin
    if (!aresetn || !port_enable_flag || mode_fault) begin
      cnt_reg <= '0;
      loaded_reg <= 1'b0;
      s_mid_reg <= 1'b0;
    end else if (as_slave && sel_fall &&
                 select_mode_field == spm_pkg::SEL_4W_IN) begin
      cnt_reg <= '0;
      loaded_reg <= 1'b0;
      s_mid_reg <= 1'b0;
    end else begin
      if (m_fall || s_fall) cnt_reg <= cnt_reg + spm_pkg::CNT_W'(1);
      // Slave bit half done: shift register locked
      if (s_rise) s_mid_reg <= 1'b1;
      else if (s_fall) s_mid_reg <= 1'b0;
      if (tx_load && as_slave) loaded_reg <= 1'b1;
      else if (byte_done) loaded_reg <= 1'b0;
    end
  end

  // Transmit buffer with collision detection
  assign wcol = do_write && wr_hit && is_addr(awaddr_reg, spm_pkg::OFS_DATA) &&
                tx_full_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buf_reg <= '0;
      tx_full_reg <= 1'b0;
    end else begin
      if (do_write && wr_hit && is_addr(awaddr_reg, spm_pkg::OFS_DATA) &&
          !tx_full_reg) begin
        tx_buf_reg <= wdata_reg[spm_pkg::BYTE_W-1:0];
        tx_full_reg <= 1'b1;
      end else if (tx_load) begin
        tx_full_reg <= 1'b0;
      end
    end
  end

  // Receive buffer; reading the data register frees it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_buf_reg <= '0;
      rx_full_reg <= 1'b0;
    end else begin
      if (byte_done && !(rx_full_reg && as_slave)) begin
        rx_buf_reg <= {shift_reg[spm_pkg::BYTE_W-2:0], bit_reg};
        rx_full_reg <= 1'b1;
      end else if (rd_data_hit) begin
        rx_full_reg <= 1'b0;
      end
    end
  end

  // Control register; fault clears both enables
  assign wr_hit = do_write && wstrb0_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_enable_flag <= spm_pkg::CTRL_RESET[spm_pkg::CTRL_PORT_EN];
      master_enable_flag <= spm_pkg::CTRL_RESET[spm_pkg::CTRL_MASTER_EN];
      select_mode_lower_bit <= spm_pkg::CTRL_RESET[spm_pkg::CTRL_SEL_LO];
      select_mode_upper_bit <= spm_pkg::CTRL_RESET[spm_pkg::CTRL_SEL_HI];
    end else if (mode_fault) begin
      port_enable_flag <= 1'b0;
      master_enable_flag <= 1'b0;
    end else if (wr_hit && is_addr(awaddr_reg, spm_pkg::OFS_CTRL)) begin
      port_enable_flag <= wdata_reg[spm_pkg::CTRL_PORT_EN];
      master_enable_flag <= wdata_reg[spm_pkg::CTRL_MASTER_EN];
      select_mode_lower_bit <= wdata_reg[spm_pkg::CTRL_SEL_LO];
      select_mode_upper_bit <= wdata_reg[spm_pkg::CTRL_SEL_HI];
    end
  end

  // Mask and divider registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= spm_pkg::MASK_RESET;
      div_reg <= spm_pkg::DIV_RESET;
    end else begin
      if (wr_hit && is_addr(awaddr_reg, spm_pkg::OFS_MASK)) begin
        mask_reg <= wdata_reg[spm_pkg::EVT_W-1:0];
      end
      if (wr_hit && is_addr(awaddr_reg, spm_pkg::OFS_DIV)) begin
        div_reg <= wdata_reg[spm_pkg::DIV_W-1:0];
      end
    end
  end

  // Sticky status, write one to clear, set wins
  always_comb begin
    status_next = status_reg;
    if (wr_hit && is_addr(awaddr_reg, spm_pkg::OFS_STATUS)) begin
      status_next = status_next & ~wdata_reg[spm_pkg::EVT_W-1:0];
    end
    if (byte_done) status_next[spm_pkg::ST_DONE] = 1'b1;
    if (mode_fault) status_next[spm_pkg::ST_FAULT] = 1'b1;
    if (wcol) status_next[spm_pkg::ST_WCOL] = 1'b1;
    if (byte_done && rx_full_reg && as_slave) begin
      status_next[spm_pkg::ST_OVRN] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  // Level interrupt from unmasked status
  assign irq = |(status_reg & mask_reg);

  // Write address and data taken in either order
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
  assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb0_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= spm_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awaddr_reg) ? spm_pkg::RESP_OKAY : spm_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel, one outstanding read
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_data_hit = s_axi_arvalid && s_axi_arready &&
                       is_addr(s_axi_araddr, spm_pkg::OFS_DATA);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= spm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? spm_pkg::RESP_OKAY : spm_pkg::RESP_SLVERR;
      s_axi_rdata <= '0;
      if (is_addr(s_axi_araddr, spm_pkg::OFS_CTRL)) begin
        s_axi_rdata[spm_pkg::CTRL_W-1:0] <= {select_mode_upper_bit, select_mode_lower_bit,
                                             master_enable_flag, port_enable_flag};
      end else if (is_addr(s_axi_araddr, spm_pkg::OFS_STATUS)) begin
        s_axi_rdata[spm_pkg::EVT_W-1:0] <= status_reg;
      end else if (is_addr(s_axi_araddr, spm_pkg::OFS_MASK)) begin
        s_axi_rdata[spm_pkg::EVT_W-1:0] <= mask_reg;
      end else if (is_addr(s_axi_araddr, spm_pkg::OFS_DATA)) begin
        s_axi_rdata[spm_pkg::BYTE_W-1:0] <= rx_buf_reg;
      end else if (is_addr(s_axi_araddr, spm_pkg::OFS_DIV)) begin
        s_axi_rdata[spm_pkg::DIV_W-1:0] <= div_reg;
      end else if (is_addr(s_axi_araddr, spm_pkg::OFS_PINS)) begin
        s_axi_rdata[6:0] <= {sel_routed, sck_oe, miso_oe, mosi_oe,
                             mstate_reg != spm_pkg::SPM_M_IDLE, rx_full_reg, tx_full_reg};
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // spm_top

/* File: design/spm_pkg.sv */
// Constants, register map and types of the serial port pin and select logic
// Functional notes
// - Master drives data out from shift MSB
// - Data lines swap direction between master and slave
// - Slave data out floats when disabled or unselected
// - Three-wire slave always drives slave data out
// - Serial clock driven only as master
// - Four-wire slave ignores clock while deselected
// - Select mode 00: three-wire, always selected
// - Select mode 01: select pin is input
// - Select falling as multi-master disables master
// - Upper mode bit set: select output equals lower
// - Select routed to pin except three-wire
// - Mode fault clears enables, sets fault flag
// - Select falling edge resets slave bit counter
// - Eighth slave bit sets done, fills receive only if empty
package spm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 3;
  localparam int EVT_W = 4;
  localparam int CTRL_W = 4;
  localparam int DIV_W = 8;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DATA = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_DIV = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PINS = 8'h14;
  // Control field positions
  localparam int CTRL_PORT_EN = 0;
  localparam int CTRL_MASTER_EN = 1;
  localparam int CTRL_SEL_LO = 2;
  localparam int CTRL_SEL_HI = 3;
  // Status and mask field positions
  localparam int ST_DONE = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_WCOL = 2;
  localparam int ST_OVRN = 3;
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h4;
  localparam logic [EVT_W-1:0] MASK_RESET = 4'h0;
  localparam logic [DIV_W-1:0] DIV_RESET = 8'h03;
  // Select mode codes
  localparam logic [1:0] SEL_3WIRE = 2'h0;
  localparam logic [1:0] SEL_4W_IN = 2'h1;
  // Bus response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Master shift sequencer states
  typedef enum logic [2:0] {
    SPM_M_IDLE = 3'b001,
    SPM_M_LOW = 3'b010,
    SPM_M_HIGH = 3'b100
  } spm_mstate_t;
endpackage

/* File: design/spm_sync.sv */
// Two-stage synchroniser for pin inputs
module spm_sync #(
  parameter int WIDTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  initial begin
    if (WIDTH < 1) $error("spm_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // spm_sync

/* File: design/spm_clk_div.sv */
// Half-period tick generator for the master serial clock
module spm_clk_div #(
  parameter int DIV_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [DIV_W-1:0] half_div,
  output logic tick
);
  logic [DIV_W-1:0] cnt_reg;

  initial begin
    if (DIV_W < 1) $error("spm_clk_div: DIV_W must be at least 1");
  end

  // Tick every half_div+1 clocks while running
  assign tick = run && (cnt_reg == half_div);

  always_ff @(posedge aclk) begin
    if (!aresetn || !run || tick) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + DIV_W'(1);
    end
  end
endmodule // spm_clk_div

/* File: tb/spm_props.sv */
// Checker for pin directions, serial clock shape and bus answer timing
module spm_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic mosi_out,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic sel_in_n,
  input wire logic sel_oe,
  input wire logic sel_routed
);
  logic [1:0] hi_cnt;
  // Cycles the select pin has stayed high, so the synchroniser has settled
  always_ff @(posedge aclk) begin
    if (!aresetn || !sel_in_n) begin
      hi_cnt <= 2'h0;
    end else if (hi_cnt != 2'h3) begin
      hi_cnt <= hi_cnt + 2'h1;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Half periods of the serial clock at the reset divider of 3
  sequence s_high;
    sck_out[*4] ##1 !sck_out;
  endsequence
  sequence s_low;
    !sck_out[*4];
  endsequence
  a_master_pins: assert property (sck_oe |-> mosi_oe && !miso_oe)
    else $error("master pin directions wrong");
  a_slave_pins: assert property (miso_oe |-> !mosi_oe && !sck_oe)
    else $error("slave pin directions wrong");
  a_sel_routed: assert property (sel_oe |-> sel_routed)
    else $error("select output not routed");
  a_desel_float: assert property (sel_routed && !sel_oe && hi_cnt == 2'h3 |-> !miso_oe)
    else $error("slave data out driven while deselected");
  a_mosi_stable: assert property (sck_out && $past(sck_out) |-> $stable(mosi_out))
    else $error("data out moved while clock high");
  a_sck_high: assert property ($rose(sck_out) |-> s_high)
    else $error("clock high phase length wrong");
  a_sck_low: assert property ($fell(sck_out) |-> s_low)
    else $error("clock low phase length wrong");
  a_fault_drop: assert property (sck_oe && sel_routed && !sel_oe && $fell(sel_in_n)
    |-> ##[1:8] !sck_oe)
    else $error("master not dropped on select fall");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
endmodule // spm_props
bind spm_top spm_props spm_props_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .sck_out, .sck_oe, .mosi_out, .mosi_oe, .miso_oe, .sel_in_n, .sel_oe,
  .sel_routed);

/* File: tb/spm_peer.sv */
// Far-side serial party: external master with select, or lone external slave
module spm_peer (
  input wire logic sck_dev,
  input wire logic miso_w,
  output logic sck_m,
  output logic mosi_m,
  output logic miso_s,
  output logic sel_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sr;
  initial begin
    sck_m = 1'b0;
    mosi_m = 1'b0;
    sel_n = 1'b1;
    sr = 8'h00;
  end
  // Lone slave reply, MSB first, shifted on falling clock
  always @(negedge sck_dev) begin
    sr <= {sr[6:0], ~sr[7]};
  end
  assign miso_s = sr[7];
  task load(input logic [7:0] b);
    sr = b;
  endtask
  // Master frame at a 320 ns clock that stands low between frames
  task automatic xfer(input logic [7:0] tx, input int nb, input logic use_sel,
                      output logic [7:0] rx);
    rx = 8'h00;
    #7;
    if (use_sel) sel_n = 1'b0;
    #160;
    for (int i = 0; i < nb; i++) begin
      mosi_m = tx[7-i];
      #160;
      sck_m = 1'b1;
      rx = {rx[6:0], miso_w};
      #160;
      sck_m = 1'b0;
    end
    #160;
    mosi_m = ~mosi_m;
    sel_n = 1'b1;
    #160;
  endtask
endmodule // spm_peer

/* File: tb/tb.sv */
// Self-checking bench for the serial port pin and select logic
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic sck_in, sck_out, sck_oe, mosi_in, mosi_out, mosi_oe, miso_in, miso_out, miso_oe;
  logic sel_in_n, sel_out_n, sel_oe, sel_routed, irq, p_sck, p_mosi, p_miso, p_sel;
  logic [7:0] prx;
  int bad_count = 0;
  int checks_done = 0;
  // Wire levels from the device's enables, else the peer's drive
  assign sck_in = sck_oe ? sck_out : p_sck;
  assign mosi_in = mosi_oe ? mosi_out : p_mosi;
  assign miso_in = miso_oe ? miso_out : p_miso;
  assign sel_in_n = sel_oe ? sel_out_n : p_sel;
  spm_top spm_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sck_in, .sck_out, .sck_oe,
    .mosi_in, .mosi_out, .mosi_oe, .miso_in, .miso_out, .miso_oe, .sel_in_n, .sel_out_n,
    .sel_oe, .sel_routed, .irq);
  spm_peer spm_peer_i (.sck_dev(sck_in), .miso_w(miso_in), .sck_m(p_sck), .mosi_m(p_mosi),
    .miso_s(p_miso), .sel_n(p_sel));
  // System clock
  initial begin
    forever #20 aclk = ~aclk;
  end
  task summarize;
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task hang;
    bad_count++;
    summarize();
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Pin vector: sck_oe mosi_oe miso_oe sel_oe sel_out_n sel_routed irq
  task pins(input logic [6:0] e);
    logic [6:0] g;
    @(negedge aclk);
    g = {sck_oe, mosi_oe, miso_oe, sel_oe, sel_out_n, sel_routed, irq};
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 50) hang();
  endtask
  task rd_reg(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 50) hang();
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task expect_rd(input logic [7:0] a, input logic [31:0] e);
    rd_reg(a);
    chk(rd, e);
  endtask
  task t_reset;
    expect_rd(spm_pkg::OFS_CTRL, 32'h4);
    expect_rd(spm_pkg::OFS_MASK, 32'h0);
    expect_rd(spm_pkg::OFS_DIV, 32'h3);
    expect_rd(spm_pkg::OFS_STATUS, 32'h0);
    pins(7'h06);
    expect_rd(8'h40, 32'h0);
    chk(rsp, spm_pkg::RESP_SLVERR);
    wr(8'h40, 32'h1);
    chk(rsp, spm_pkg::RESP_SLVERR);
  endtask
  task t_master;
    logic [7:0] got;
    logic last;
    int n;
    wr(spm_pkg::OFS_MASK, 32'h1);
    chk(rsp, spm_pkg::RESP_OKAY);
    wr(spm_pkg::OFS_CTRL, 32'hB);
    pins(7'h6A);
    wr(spm_pkg::OFS_CTRL, 32'hF);
    pins(7'h6E);
    spm_peer_i.load(8'h3C);
    wr(spm_pkg::OFS_DATA, 32'hA5);
    got = 8'h00;
    last = 1'b0;
    for (n = 0; n < 400 && !irq; n++) begin
      @(posedge aclk);
      if (sck_out && !last) got = {got[6:0], mosi_out};
      last = sck_out;
    end
    if (n == 400) hang();
    chk(got, 32'hA5);
    expect_rd(spm_pkg::OFS_DATA, 32'h3C);
    wr(spm_pkg::OFS_MASK, 32'h0);
    pins(7'h6E);
    wr(spm_pkg::OFS_MASK, 32'h1);
    pins(7'h6F);
    wr(spm_pkg::OFS_STATUS, 32'hF);
    pins(7'h6E);
  endtask
  task t_slave3;
    wr(spm_pkg::OFS_CTRL, 32'h3);
    pins(7'h60);
    wr(spm_pkg::OFS_CTRL, 32'h1);
    pins(7'h10);
    wr(spm_pkg::OFS_DATA, 32'h96);
    wr(spm_pkg::OFS_DATA, 32'h11);
    wr(spm_pkg::OFS_DATA, 32'h22);
    spm_peer_i.xfer(8'h5A, 8, 1'b0, prx);
    chk(prx, 32'h96);
    expect_rd(spm_pkg::OFS_STATUS, 32'h5);
    spm_peer_i.xfer(8'h77, 8, 1'b0, prx);
    chk(prx, 32'h11);
    expect_rd(spm_pkg::OFS_STATUS, 32'hD);
    expect_rd(spm_pkg::OFS_DATA, 32'h5A);
    wr(spm_pkg::OFS_STATUS, 32'hF);
  endtask
  task t_slave4;
    wr(spm_pkg::OFS_CTRL, 32'h5);
    pins(7'h06);
    spm_peer_i.xfer(8'hFF, 8, 1'b0, prx);
    expect_rd(spm_pkg::OFS_STATUS, 32'h0);
    wr(spm_pkg::OFS_DATA, 32'hC3);
    spm_peer_i.xfer(8'h81, 3, 1'b1, prx);
    chk(prx, 32'h6);
    spm_peer_i.xfer(8'h4E, 8, 1'b1, prx);
    expect_rd(spm_pkg::OFS_DATA, 32'h4E);
    wr(spm_pkg::OFS_STATUS, 32'hF);
  endtask
  task t_fault;
    wr(spm_pkg::OFS_MASK, 32'h2);
    wr(spm_pkg::OFS_CTRL, 32'h7);
    pins(7'h66);
    spm_peer_i.xfer(8'h00, 0, 1'b1, prx);
    expect_rd(spm_pkg::OFS_CTRL, 32'h4);
    expect_rd(spm_pkg::OFS_STATUS, 32'h2);
    pins(7'h07);
  endtask
  // Reset, then the scenarios in turn
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_master();
    t_slave3();
    t_slave4();
    t_fault();
    summarize();
  end
endmodule // tb
